// ### snv_ctrl.sv
// serial command decoder, protection latches and array transfers
// assumes all pins asynchronous to SYS_CLK; RST_N is power-up
`timescale 1ns/1ps
`default_nettype none

module snv_fifo
    import snv_pkg::*;
#(
    parameter int W     = 20,
    parameter int DEPTH = 16
) (
    input  wire logic         clk,       // system clock
    input  wire logic         rst_n,     // async reset
    input  wire logic         in_valid,  // push request
    output logic              in_ready,  // not full
    input  wire logic [W-1:0] in_data,   // pushed word
    output logic              out_valid, // not empty
    input  wire logic         out_ready, // drain may take
    output logic [W-1:0]      out_data   // head word
);
    localparam int PW = $clog2(DEPTH);
    typedef struct packed {
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0]   cnt;
    } snv_fptr_t;
    snv_fptr_t      r;
    snv_fptr_t      nx;
    logic [W-1:0]   mem [DEPTH];
    logic           push;
    logic           pop;

    assign in_ready  = r.cnt != (PW+1)'(DEPTH);
    assign out_valid = r.cnt != '0;
    assign out_data  = mem[r.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        nx = r;
        if (push) begin
            nx.wp = r.wp + 1'b1;
        end
        if (pop) begin
            nx.rp = r.rp + 1'b1;
        end
        nx.cnt = r.cnt + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= nx;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[r.wp] <= in_data;
        end
    end
endmodule : snv_fifo

// Notes on behaviour
// (RULE1) rising serial clock shifts 8-bit instruction
// (RULE2) msb first, address 6..3, opcode 2..0
// (RULE3) input ignored until a start one
// (RULE4) stopped serial clock freezes all shifting
// (RULE5) chip select low clears instruction register
// (RULE6) opcode decode per instruction set
// (RULE7) reload command or pin copies, sets latch
// (RULE8) power-up reload leaves reload latch clear
// (RULE9) writes and commits need write-enable latch; the supply-drop auto-commit does not check it
// (RULE10) write-enable latch cleared at power-up
// (RULE11) commit needs both latches set; the supply-drop auto-commit checks neither
// (RULE12) commit blocks all; clears write-enable
// (RULE13) commit 5 ms, reload 2 us
// (RULE14) write: address then 16 data bits
// (RULE15) early deselect still writes shifted bits
// (RULE16) beyond 24 clocks data is overwritten
// (RULE17) read: first bit on eighth falling edge
// (RULE18) serial output driven only during read data
// (RULE19) armed latch commits on supply drop
// (RULE20) supply-fail open-drain, low while supply low
// (RULE21) commands ignored during power-up reload
// (RULE22) host waits 200 us read, 5 ms write
// (RULE23) supply-low is a synchronised digital input
module snv_ctrl
    import snv_pkg::*;
#(
    parameter int COMMIT_CYCLES = COMMIT_CYC
) (
    input  wire logic SYS_CLK,         // 100 MHz system clock
    input  wire logic RST_N,           // power-up reset, async
    input  wire logic CHIP_SELECT,     // host chip select, high active
    input  wire logic SERIAL_CLOCK,    // host serial clock
    input  wire logic SERIAL_IN,       // host serial data
    input  wire logic RELOAD_N,        // hardware reload, low active
    input  wire logic SUPPLY_LOW,      // supply below threshold
    output logic      SERIAL_OUT,      // read data bit
    output logic      SERIAL_OUT_OE,   // read data driven
    output logic      SUPPLY_FAIL_N_O, // open-drain level, always 0
    output logic      SUPPLY_FAIL_OE,  // pulls flag low
    output logic      WRITE_ENABLED,   // write-enable latch
    output logic      PREV_RELOADED,   // previous-reload latch
    output logic      AUTO_ARMED,      // auto-commit latch
    output logic      NV_BUSY          // reload or commit running
);
    typedef struct packed {
        snv_pins_t          s1;
        snv_pins_t          s2;
        logic               sk_d;
        logic               low_d;
        snv_sh_t            sh;
        logic [7:0]         instr;
        logic [4:0]         bcnt;
        logic [ADDR_W-1:0]  addr;
        logic [WORD_W-1:0]  sreg;
        logic [4:0]         wbits;
        snv_nv_t            nv;
        logic [TMR_W-1:0]   tmr;
        logic               wen;
        logic               prev;
        logic               arm;
        logic               pend;
        snv_word_t          pword;
        logic               so;
        logic               so_oe;
        logic               fail_oe;
    } snv_st_t;

    snv_st_t        r;
    snv_st_t        nx;
    logic [WORD_W-1:0] ram [WORDS];
    logic [WORD_W-1:0] eep [WORDS];
    logic           do_reload;
    logic           do_commit;
    logic           f_ready;
    logic           f_valid;
    logic           f_take;
    snv_word_t      f_word;
    logic           sk_rise;
    logic           sk_fall;
    logic           gate;

    assign SERIAL_OUT      = r.so;
    assign SERIAL_OUT_OE   = r.so_oe;
    assign SUPPLY_FAIL_N_O = 1'b0;
    assign SUPPLY_FAIL_OE  = r.fail_oe;
    assign WRITE_ENABLED   = r.wen;
    assign PREV_RELOADED   = r.prev;
    assign AUTO_ARMED      = r.arm;
    assign NV_BUSY         = r.nv != NV_IDLE;

    // (RULE4) edges only from sampled clock, none when static
    assign sk_rise = r.s2.serial_clock && !r.sk_d;
    assign sk_fall = !r.s2.serial_clock && r.sk_d;
    // (RULE12) blocked while busy or words pending
    assign gate    = (r.nv == NV_IDLE) && !r.pend && !f_valid;
    // drain stalls during transfers so the buffer can fill
    assign f_take  = r.nv == NV_IDLE;

    snv_fifo #(
        .W     ($bits(snv_word_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (SYS_CLK),
        .rst_n     (RST_N),
        .in_valid  (r.pend),
        .in_ready  (f_ready),
        .in_data   (r.pword),
        .out_valid (f_valid),
        .out_ready (f_take),
        .out_data  (f_word)
    );

    always_comb begin
        nx = r;
        do_reload = 1'b0;
        do_commit = 1'b0;
        // (RULE23) two-stage pin synchronisers
        nx.s1 = '{CHIP_SELECT, SERIAL_CLOCK, SERIAL_IN, RELOAD_N,
                  SUPPLY_LOW};
        nx.s2 = r.s1;
        nx.sk_d = r.s2.serial_clock;
        nx.low_d = r.s2.supply_low;
        // (RULE20) open-drain flag follows supply low
        nx.fail_oe = r.s2.supply_low;
        if (r.pend && f_ready) begin
            nx.pend = 1'b0;
        end

        if (!r.s2.chip_select) begin
            // (RULE5) deselect clears instruction register
            nx.sh    = SH_HUNT;
            nx.instr = '0;
            nx.bcnt  = '0;
            nx.so_oe = 1'b0;
            // (RULE15) partial or full word written at deselect
            if (r.sh == SH_WDATA && r.wbits != '0 && r.wen) begin
                nx.pend  = 1'b1;
                nx.pword = '{r.addr, r.sreg};
            end
        end else if (r.nv != NV_IDLE) begin
            // (RULE12) transfers abort an open frame
            nx.sh    = SH_DONE;
            nx.so_oe = 1'b0;
        end else begin
            unique case (r.sh)
                SH_HUNT: begin
                    // (RULE3) wait for start one
                    // (RULE21) ignored while busy
                    if (sk_rise && r.s2.serial_in && gate) begin
                        nx.sh    = SH_INSTR;
                        nx.instr = 8'h01;
                        nx.bcnt  = 5'h01;
                    end
                end
                SH_INSTR: begin
                    if (sk_rise) begin
                        // (RULE1) shift on rising edge
                        // (RULE2) msb first
                        nx.instr = {r.instr[6:0], r.s2.serial_in};
                        nx.bcnt  = r.bcnt + 5'h01;
                        // (RULE17) read known after seven bits
                        if (nx.bcnt == READ_SIG_BITS &&
                            nx.instr[1:0] == OP_READ_HI) begin
                            nx.sh   = SH_RWAIT;
                            nx.addr = nx.instr[5:2];
                            nx.sreg = ram[nx.instr[5:2]];
                        end else if (nx.bcnt == INSTR_BITS) begin
                            nx.sh   = SH_DONE;
                            nx.addr = nx.instr[6:3];
                            // (RULE6) opcode decode
                            unique case (nx.instr[2:0])
                                OP_LOCK: begin
                                    // (RULE9) lock clears latch
                                    nx.wen = 1'b0;
                                end
                                OP_UNLOCK: begin
                                    // (RULE9) unlock sets latch
                                    nx.wen = 1'b1;
                                end
                                OP_ARM: begin
                                    // (RULE19) arm auto-commit
                                    nx.arm = 1'b1;
                                end
                                OP_COMMIT: begin
                                    // (RULE11) both latches needed
                                    do_commit = r.wen && r.prev;
                                end
                                OP_RELOAD: begin
                                    do_reload = 1'b1;
                                end
                                OP_WRITE: begin
                                    // (RULE14) data follows at once
                                    nx.sh    = SH_WDATA;
                                    nx.sreg  = '0;
                                    nx.wbits = '0;
                                end
                                default: begin
                                    nx.sh = SH_DONE;
                                end
                            endcase
                        end
                    end
                end
                SH_RWAIT: begin
                    // (RULE17) first bit on eighth falling edge
                    if (sk_fall && r.bcnt == INSTR_BITS) begin
                        nx.sh    = SH_RDATA;
                        nx.so    = r.sreg[WORD_W-1];
                        nx.sreg  = {r.sreg[WORD_W-2:0], 1'b0};
                        nx.so_oe = 1'b1;
                        nx.wbits = 5'h01;
                    end else if (sk_rise) begin
                        nx.bcnt = INSTR_BITS;
                    end
                end
                SH_RDATA: begin
                    if (sk_rise) begin
                        // (RULE18) released after last bit
                        if (r.wbits == DATA_BITS) begin
                            nx.sh    = SH_DONE;
                            nx.so_oe = 1'b0;
                        end else begin
                            nx.so    = r.sreg[WORD_W-1];
                            nx.sreg  = {r.sreg[WORD_W-2:0], 1'b0};
                            nx.wbits = r.wbits + 5'h01;
                        end
                    end
                end
                SH_WDATA: begin
                    if (sk_rise) begin
                        // (RULE16) keeps shifting past 16 bits
                        nx.sreg = {r.sreg[WORD_W-2:0], r.s2.serial_in};
                        if (r.wbits != DATA_BITS) begin
                            nx.wbits = r.wbits + 5'h01;
                        end
                    end
                end
                SH_DONE: begin
                    nx.sh = SH_DONE;
                end
                default: begin
                    nx.sh = SH_HUNT;
                end
            endcase
        end

        // hardware reload and auto-commit only when idle
        if (r.nv == NV_IDLE && !f_valid && !r.pend) begin
            // (RULE19) armed commit on supply drop
            if (r.arm && r.s2.supply_low && !r.low_d) begin
                do_commit = 1'b1;
            end else if (!r.s2.reload_n) begin
                // (RULE7) hardware reload pin
                do_reload = 1'b1;
            end
        end

        unique case (r.nv)
            NV_PWRUP, NV_RELOAD: begin
                if (r.tmr == TMR_W'(1)) begin
                    nx.nv = NV_IDLE;
                end else begin
                    nx.tmr = r.tmr - TMR_W'(1);
                end
            end
            NV_COMMIT: begin
                if (r.tmr == TMR_W'(1)) begin
                    nx.nv = NV_IDLE;
                    // (RULE12) commit end clears write enable
                    nx.wen = 1'b0;
                end else begin
                    nx.tmr = r.tmr - TMR_W'(1);
                end
            end
            NV_IDLE: begin
                if (do_commit) begin
                    // (RULE13) commit window
                    nx.nv  = NV_COMMIT;
                    nx.tmr = TMR_W'(COMMIT_CYCLES);
                end else if (do_reload) begin
                    // (RULE7) reload sets previous-reload latch
                    // (RULE13) reload window
                    nx.nv   = NV_RELOAD;
                    nx.tmr  = TMR_W'(RELOAD_CYC);
                    nx.prev = 1'b1;
                end
            end
            default: begin
                nx.nv = NV_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            r       <= '0;
            r.sh    <= SH_HUNT;
            // (RULE8) power-up reload, reload latch clear
            r.nv    <= NV_PWRUP;
            r.tmr   <= TMR_W'(RELOAD_CYC);
            // (RULE10) latches cleared at power-up
            r.wen   <= LATCH_RST;
            r.prev  <= LATCH_RST;
            r.arm   <= LATCH_RST;
            r.sk_d  <= 1'b0;
        end else begin
            r <= nx;
        end
    end

    // arrays copy at the end of each transfer window
    always_ff @(posedge SYS_CLK) begin
        if ((r.nv == NV_PWRUP || r.nv == NV_RELOAD) &&
            r.tmr == TMR_W'(1)) begin
            for (int i = 0; i < WORDS; i++) begin
                ram[i] <= eep[i];
            end
        end else if (f_valid && f_take) begin
            // (RULE9) only latched-enabled words reach the buffer
            ram[f_word.addr] <= f_word.data;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (r.nv == NV_COMMIT && r.tmr == TMR_W'(1)) begin
            for (int i = 0; i < WORDS; i++) begin
                eep[i] <= ram[i];
            end
        end
    end
endmodule : snv_ctrl

`default_nettype wire

// ### snv_ctrl_props.sv
// pin-level checker for snv_ctrl, bound into every instance
// assumes one SYS_CLK domain and the async low RST_N
`timescale 1ns/1ps
`default_nettype none
module snv_ctrl_props
    import snv_pkg::*;
#(
    parameter int COMMIT_CYCLES = COMMIT_CYC
) (
    input wire logic SYS_CLK,         // system clock
    input wire logic RST_N,           // power-up reset
    input wire logic CHIP_SELECT,     // host select
    input wire logic SERIAL_CLOCK,    // host clock
    input wire logic SERIAL_IN,       // host data
    input wire logic RELOAD_N,        // hardware reload
    input wire logic SUPPLY_LOW,      // supply low
    input wire logic SERIAL_OUT,      // read bit
    input wire logic SERIAL_OUT_OE,   // read drive
    input wire logic SUPPLY_FAIL_N_O, // flag level
    input wire logic SUPPLY_FAIL_OE,  // flag drive
    input wire logic WRITE_ENABLED,   // write latch
    input wire logic PREV_RELOADED,   // reload latch
    input wire logic AUTO_ARMED,      // arm latch
    input wire logic NV_BUSY          // transfer running
);
    logic [TMR_W-1:0] busy_cnt_r;
    logic             pwrup_r;
    // busy length and power-up phase
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            busy_cnt_r <= '0;
            pwrup_r    <= 1'b1;
        end else begin
            busy_cnt_r <= NV_BUSY ? busy_cnt_r + 1'b1 : '0;
            pwrup_r    <= pwrup_r & NV_BUSY;
        end
    end
    default clocking @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_N);
    chk_oe_deselect: assert property (!CHIP_SELECT [*6] |-> !SERIAL_OUT_OE)
        else $error("data out driven while deselected");
    chk_oe_start: assert property ($rose(SERIAL_OUT_OE) |-> !$past(NV_BUSY) && $past(CHIP_SELECT, 4))
        else $error("data out started while busy or deselected");
    chk_fail_on: assert property (SUPPLY_LOW [*5] |-> SUPPLY_FAIL_OE && !SUPPLY_FAIL_N_O)
        else $error("supply flag not pulled low");
    chk_fail_off: assert property (!SUPPLY_LOW [*5] |-> !SUPPLY_FAIL_OE)
        else $error("supply flag pulled without cause");
    chk_we_idle: assert property ($rose(WRITE_ENABLED) |-> !$past(NV_BUSY) && !pwrup_r)
        else $error("write latch set while busy");
    chk_busy_bound: assert property (busy_cnt_r <= COMMIT_CYCLES + 4)
        else $error("transfer too long");
    chk_reload_bound: assert property (pwrup_r |-> busy_cnt_r <= RELOAD_CYC + 2)
        else $error("power-up reload too long");
    chk_latch_reset: assert property (pwrup_r |-> !WRITE_ENABLED && !PREV_RELOADED && !AUTO_ARMED)
        else $error("latch set during power-up");
    chk_arm_hold: assert property (NV_BUSY && $past(NV_BUSY) |-> $stable(AUTO_ARMED))
        else $error("arm latch changed while busy");
endmodule : snv_ctrl_props
bind snv_ctrl snv_ctrl_props #(.COMMIT_CYCLES(COMMIT_CYCLES)) i_props (
    .SYS_CLK, .RST_N, .CHIP_SELECT, .SERIAL_CLOCK, .SERIAL_IN, .RELOAD_N,
    .SUPPLY_LOW, .SERIAL_OUT, .SERIAL_OUT_OE, .SUPPLY_FAIL_N_O,
    .SUPPLY_FAIL_OE, .WRITE_ENABLED, .PREV_RELOADED, .AUTO_ARMED, .NV_BUSY
);
`default_nettype wire

// ### snv_ctrl_test.sv
// self-checking bench for snv_ctrl with the host model
// assumes snv_pkg, snv_host and the bound checker
`timescale 1ns/1ps
`default_nettype none
module snv_ctrl_test
    import snv_pkg::*;
;
    localparam int CC = 400;
    logic        clk        = 1'b0;
    logic        rst_n      = 1'b0;
    logic        reload_n   = 1'b1;
    logic        supply_low = 1'b0;
    logic        cs, sck, sdi, so, oe, fl_o, fl_oe, we, pr, arm, busy;
    wire logic   sdo_w;
    wire logic   fail_n;
    int          num_errors = 0;
    int          checks     = 0;
    logic [15:0] rd;
    assign sdo_w  = oe ? so : 1'bz;
    assign fail_n = fl_oe ? fl_o : 1'b1;
    always #5 clk = ~clk;
    snv_host i_host (.clk(clk), .cs(cs), .sck(sck), .sdi(sdi), .sdo(sdo_w));
    snv_ctrl #(.COMMIT_CYCLES(CC)) i_dut (
        .SYS_CLK(clk), .RST_N(rst_n), .CHIP_SELECT(cs), .SERIAL_CLOCK(sck),
        .SERIAL_IN(sdi), .RELOAD_N(reload_n), .SUPPLY_LOW(supply_low),
        .SERIAL_OUT(so), .SERIAL_OUT_OE(oe), .SUPPLY_FAIL_N_O(fl_o),
        .SUPPLY_FAIL_OE(fl_oe), .WRITE_ENABLED(we), .PREV_RELOADED(pr),
        .AUTO_ARMED(arm), .NV_BUSY(busy)
    );
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic complete_run;
        $display("checks=%0d mismatches=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run
    task automatic wait_idle(input int bound);
        int n = 0;
        while (busy !== 1'b0 && n < bound) begin
            @(negedge clk);
            n++;
        end
        if (busy !== 1'b0) begin
            num_errors++;
            complete_run();
        end
    endtask : wait_idle
    task automatic do_reset;
        rst_n = 1'b0;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
    endtask : do_reset
    task automatic t_powerup;
        check(16'(busy), 16'h1);
        check(16'({we, pr, arm}), 16'h0);
        i_host.cmd(OP_UNLOCK);
        wait_idle(RELOAD_CYC + 10);
        check(16'({we, pr}), 16'h0);
        $display("test powerup done");
    endtask : t_powerup
    task automatic t_protect;
        i_host.write(4'h2, 32'h1234, 16);
        i_host.open_frame();
        i_host.shift(32'h0, 3);
        i_host.shift({24'h0, 5'h10, OP_UNLOCK}, 8);
        i_host.close_frame();
        check(16'(we), 16'h1);
        i_host.write(4'h2, 32'ha5c3, 16);
        i_host.read(4'h2, 1'b0, rd);
        check(rd, 16'ha5c3);
        check(16'(sdo_w), 16'(1'bz));
        i_host.cmd(OP_LOCK);
        check(16'(we), 16'h0);
        i_host.write(4'h2, 32'h1234, 16);
        i_host.read(4'h2, 1'b1, rd);
        check(rd, 16'ha5c3);
        $display("test protect done");
    endtask : t_protect
    task automatic t_partial;
        i_host.cmd(OP_UNLOCK);
        i_host.write(4'h5, 32'hb7, 8);
        i_host.write(4'h6, 32'h9c3e1, 20);
        i_host.read(4'h5, 1'b0, rd);
        check(rd, 16'h00b7);
        i_host.read(4'h6, 1'b0, rd);
        check(rd, 16'hc3e1);
        $display("test partial done");
    endtask : t_partial
    task automatic t_commit;
        i_host.cmd(OP_COMMIT);
        check(16'(busy), 16'h0);
        i_host.cmd(OP_RELOAD);
        wait_idle(RELOAD_CYC + 10);
        check(16'(pr), 16'h1);
        i_host.write(4'h2, 32'h5a3c, 16);
        i_host.cmd(OP_COMMIT);
        check(16'(busy), 16'h1);
        i_host.read(4'h2, 1'b0, rd);
        check(rd, 16'hzzzz);
        wait_idle(CC + 10);
        check(16'(we), 16'h0);
        i_host.cmd(OP_UNLOCK);
        i_host.write(4'h2, 32'h0ff0, 16);
        i_host.cmd(OP_RELOAD);
        wait_idle(RELOAD_CYC + 10);
        i_host.read(4'h2, 1'b0, rd);
        check(rd, 16'h5a3c);
        $display("test commit done");
    endtask : t_commit
    task automatic t_auto;
        supply_low = 1'b1;
        repeat (6) @(negedge clk);
        check(16'({fail_n, busy}), 16'h0);
        supply_low = 1'b0;
        repeat (6) @(negedge clk);
        check(16'(fail_n), 16'h1);
        i_host.cmd(OP_ARM);
        check(16'(arm), 16'h1);
        supply_low = 1'b1;
        repeat (6) @(negedge clk);
        check(16'({fail_n, busy}), 16'h1);
        wait_idle(CC + 10);
        supply_low = 1'b0;
        $display("test auto done");
    endtask : t_auto
    task automatic t_hwreload;
        do_reset();
        wait_idle(RELOAD_CYC + 10);
        check(16'({we, pr, arm}), 16'h0);
        i_host.read(4'h2, 1'b0, rd);
        check(rd, 16'h5a3c);
        reload_n = 1'b0;
        repeat (5) @(negedge clk);
        reload_n = 1'b1;
        check(16'(busy), 16'h1);
        wait_idle(RELOAD_CYC + 10);
        check(16'(pr), 16'h1);
        $display("test hwreload done");
    endtask : t_hwreload
    initial begin
        do_reset();
        t_powerup();
        t_protect();
        t_partial();
        t_commit();
        t_auto();
        t_hwreload();
        complete_run();
    end
endmodule : snv_ctrl_test
`default_nettype wire

// ### snv_host.sv
// host model driving the four-wire serial port
// assumes clk only paces it; link clock period 80 ns, parked low
`timescale 1ns/1ps
`default_nettype none
module snv_host
    import snv_pkg::*;
(
    input  wire logic clk, // pacing clock
    output var logic  cs,  // chip select
    output var logic  sck, // link clock
    output var logic  sdi, // data to device
    input  wire logic sdo  // data from device
);
    initial begin
        cs  = 1'b0;
        sck = 1'b0;
        sdi = 1'b0;
    end
    task automatic tick(input logic b);
        sdi = b;
        repeat (4) @(negedge clk);
        sck = 1'b1;
        repeat (4) @(negedge clk);
        sck = 1'b0;
    endtask : tick
    task automatic shift(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            tick(v[i]);
        end
    endtask : shift
    task automatic open_frame;
        @(negedge clk);
        cs = 1'b1;
        repeat (8) @(negedge clk);
    endtask : open_frame
    task automatic close_frame;
        @(negedge clk);
        cs  = 1'b0;
        sdi = ~sdi;
        repeat (8) @(negedge clk);
    endtask : close_frame
    task automatic cmd(input logic [2:0] op);
        open_frame();
        shift({24'h0, 5'h10, op}, 8);
        close_frame();
    endtask : cmd
    task automatic write(input logic [3:0] a, input logic [31:0] d, input int n);
        open_frame();
        shift({24'h0, 1'b1, a, OP_WRITE}, 8);
        shift(d, n);
        close_frame();
    endtask : write
    task automatic read(input logic [3:0] a, input logic x, output logic [15:0] d);
        open_frame();
        shift({24'h0, 1'b1, a, OP_READ_HI, x}, 8);
        // clock parked low between first bit and ninth rise
        repeat (20) @(negedge clk);
        for (int i = 15; i >= 0; i--) begin
            d[i] = sdo;
            tick(~sdi);
        end
        close_frame();
    endtask : read
endmodule : snv_host
`default_nettype wire

// ### snv_pkg.sv
// constants and types for the serial shadowed-ram controller
// assumes a 100 MHz system clock; no bus, all control on pins
package snv_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int RELOAD_MAX_NS = 2000;
    localparam int RELOAD_CYC    = RELOAD_MAX_NS / CLK_PERIOD_NS;
    localparam int COMMIT_MAX_MS = 5;
    localparam int COMMIT_CYC    = COMMIT_MAX_MS * 1000000 / CLK_PERIOD_NS;
    localparam int TMR_W         = 20;
    localparam int WORD_W        = 16;
    localparam int ADDR_W        = 4;
    localparam int WORDS         = 16;
    localparam int FIFO_DEPTH    = 16;
    localparam logic [4:0] READ_SIG_BITS = 5'h07;
    localparam logic [4:0] INSTR_BITS    = 5'h08;
    localparam logic [4:0] DATA_BITS     = 5'h10;
    localparam logic [2:0] OP_LOCK   = 3'h0;
    localparam logic [2:0] OP_COMMIT = 3'h1;
    localparam logic [2:0] OP_ARM    = 3'h2;
    localparam logic [2:0] OP_WRITE  = 3'h3;
    localparam logic [2:0] OP_UNLOCK = 3'h4;
    localparam logic [2:0] OP_RELOAD = 3'h5;
    localparam logic [1:0] OP_READ_HI = 2'h3;
    localparam logic LATCH_RST = 1'b0;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] data;
    } snv_word_t;
    typedef struct packed {
        logic chip_select;
        logic serial_clock;
        logic serial_in;
        logic reload_n;
        logic supply_low;
    } snv_pins_t;
    typedef enum logic [3:0] {
        NV_PWRUP  = 4'b0001,
        NV_IDLE   = 4'b0010,
        NV_RELOAD = 4'b0100,
        NV_COMMIT = 4'b1000
    } snv_nv_t;
    typedef enum logic [5:0] {
        SH_HUNT  = 6'b000001,
        SH_INSTR = 6'b000010,
        SH_RWAIT = 6'b000100,
        SH_RDATA = 6'b001000,
        SH_WDATA = 6'b010000,
        SH_DONE  = 6'b100000
    } snv_sh_t;
endpackage : snv_pkg
